// *** rtl/ddrt_ctrl.sv ***
// Controller end: APB-driven command issue with timing guards
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - Minimums counted in real link clock edges
// R2 - Never issue out-of-spec sequences; reinit otherwise
// R3 - Write recovery is programmed cycle count
// R4 - Device accepts rounded-up nanosecond cycle counts
// R5 - Write recovery time rounded up for gap
// R6 - Internal write starts latency plus four/two
// R7 - Clock enable low allowed during row work
// R8 - Refresh-to-powerdown gap before clock enable low
// R9 - Short ODT time measured from registered high
// R10 - Long ODT time from eight-beat write
// R11 - Short calibration finishes within sixty-four edges
// R12 - Only read and sync ODT need DLL
// R13 - At most nine refreshes outstanding, then force
// R14 - Any clock rate, refresh interval still met
// R15 - Refresh interval chosen by operating temperature
// R16 - ODT high four edges without long write
// R17 - ODT high six edges with long write
// R18 - Wait DLL gap after powerdown exit
// R19 - One edge from refresh to powerdown
// R20 - Counters gate each dependent command
module ddrt_ctrl
   import ddrt_pkg::*;
#(
   parameter int CK_HALF_P = CK_HALF
)(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   ddrt_if.ctrl link
);
   localparam int TCKP = 2 * CK_HALF_P * SYS_PS;
   localparam logic [CW-1:0] XPDLL_N =
      CW'(ddrt_max(XPDLL_MIN_CK, ddrt_ru(T_XPDLL_NS * 1000, TCKP)));
   localparam logic [CW-1:0] WR_N = CW'(ddrt_ru(T_WR_MIN_NS * 1000, TCKP));

   // Registers, guard counters and issue decisions
   logic [15:0] div_r, refi_r, ref_tmr_r, intv;
   logic ck_r, tick, rise, fall, acc, done, mapped, wr_cmd;
   logic [1:0] cfg_r;
   logic pend_r, podt_r, cke_r, odt_r, chopf_r;
   ddrt_cmd_type code_r, cmd_r, iss;
   logic [11:0] paddr_r, addr_r;
   logic [3:0] wl_r, wr_r, owed_r;
   logic [CW-1:0] pden_cnt_r, odt_cnt_r, dll_cnt_r, pden_ld, odt_ld;
   logic force_ref, odt_up, odt_dn, sw_ok, ref_go, pd_go, pd_exit, chop;

   // Link clock from a divider; edges known without sampling
   assign tick = (div_r == 16'(CK_HALF_P - 1));
   assign rise = i_ce & tick & ~ck_r;
   assign fall = i_ce & tick & ck_r;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         div_r <= 16'h0000;
         ck_r <= 1'b0;
      end
      else if (i_ce)
      begin
         div_r <= tick ? 16'h0000 : div_r + 16'h0001;
         if (tick)
            ck_r <= ~ck_r;
      end

   // APB: one wait state, write lands at the pready edge
   assign acc = i_psel & i_penable & ~o_pready;
   assign done = i_psel & i_penable & o_pready;
   assign mapped = (i_paddr == REG_CMD) | (i_paddr == REG_CFG) |
                   (i_paddr == REG_STAT) | (i_paddr == REG_REFI);
   assign wr_cmd = done & i_pwrite & ~o_pslverr & (i_paddr == REG_CMD);

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end
      else if (i_ce)
      begin
         o_pready <= acc;
         // Busy command slot refuses a new order rather than lose one
         o_pslverr <= acc & (~mapped | (i_pwrite & (i_paddr == REG_CMD) & pend_r));
         if (acc)
         begin
            o_prdata <= 32'h00000000;
            if (i_paddr == REG_CMD)
               o_prdata <= {16'h0000, paddr_r, podt_r, code_r};
            else if (i_paddr == REG_CFG)
               o_prdata <= {30'h00000000, cfg_r};
            else if (i_paddr == REG_STAT)
               o_prdata <= {16'h0000, chopf_r, wr_r, wl_r, owed_r, odt_r, ~cke_r, pend_r};
            else if (i_paddr == REG_REFI)
               o_prdata <= {16'h0000, refi_r};
         end
      end

   // Configuration: power-down request, temperature range, interval
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         cfg_r <= CFG_RST;
         refi_r <= REFI_RST;
      end
      else if (i_ce && done && i_pwrite && !o_pslverr)
      begin
         if (i_paddr == REG_CFG)
            cfg_r <= i_pwdata[1:0];
         if (i_paddr == REG_REFI)
            refi_r <= i_pwdata[15:0]; // R14
      end

   // Pending order slot
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         pend_r <= 1'b0;
         code_r <= C_NOP;
         podt_r <= 1'b0;
         paddr_r <= 12'h000;
      end
      else if (i_ce)
      begin
         if (wr_cmd)
         begin
            pend_r <= 1'b1;
            code_r <= ddrt_cmd_type'(i_pwdata[2:0]);
            podt_r <= i_pwdata[CMD_ODT];
            paddr_r <= i_pwdata[CMD_ADDR +: 12];
         end
         else if (fall && sw_ok)
            pend_r <= 1'b0;
      end

   // Issue decision; an order that would break timing just waits
   assign force_ref = (owed_r == OWED_MAX); // R13
   assign odt_up = podt_r & ~odt_r;
   assign odt_dn = ~podt_r & odt_r;
   assign sw_ok = pend_r & cke_r & ~force_ref & // R2
                  ~((code_r == C_RD | odt_up) & (dll_cnt_r != 8'h00)) & // R12 R18
                  ~(odt_dn & (odt_cnt_r != 8'h00)); // R16 R17
   assign ref_go = force_ref & cke_r; // R13
   assign pd_go = cke_r & cfg_r[CFG_PD] & ~pend_r & ~force_ref &
                  (pden_cnt_r == 8'h00); // R8 R20
   assign pd_exit = ~cke_r & (~cfg_r[CFG_PD] | force_ref);
   assign iss = ref_go ? C_REF : (sw_ok ? code_r : C_NOP);
   assign chop = chopf_r | paddr_r[A_CHOP];

   // Gap loads; row work may still run when clock enable drops
   always_comb
   begin
      pden_ld = 8'h00;
      odt_ld = 8'h00;
      case (iss)
         C_REF: pden_ld = REF_PDEN_CK; // R19
         C_ACT, C_PRE: pden_ld = ACT_PDEN_CK; // R7
         C_WR:
            pden_ld = CW'(wl_r) + (chopf_r ? WR_START_CHOP : WR_START_FULL) +
                      (paddr_r[A_AP] ? CW'(wr_r) + 8'h01 : WR_N); // R3 R5
         default: pden_ld = 8'h00;
      endcase
      if (sw_ok && podt_r && (odt_up || iss == C_WR))
         odt_ld = (iss == C_WR && !chop) ? ODT_LONG_CK : ODT_SHORT_CK; // R9 R10
   end

   // Drive the link on the falling edge, device samples on rising
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         cke_r <= 1'b1;
         odt_r <= 1'b0;
         cmd_r <= C_NOP;
         addr_r <= 12'h000;
      end
      else if (fall)
      begin
         cmd_r <= iss;
         addr_r <= ref_go ? 12'h000 : paddr_r;
         if (sw_ok)
            odt_r <= podt_r;
         if (pd_go)
            cke_r <= 1'b0;
         else if (pd_exit)
            cke_r <= 1'b1;
      end

   // Mode register zero shadow taken from issued mode sets
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         wl_r <= WL_RST;
         wr_r <= WR_RST;
         chopf_r <= 1'b0;
      end
      else if (fall && iss == C_MRS)
      begin
         wl_r <= paddr_r[A_WL +: 4];
         wr_r <= paddr_r[A_WR +: 4]; // R3
         chopf_r <= paddr_r[A_CHOP];
      end

   // Guard counters, loaded at drive and counted per link edge
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         pden_cnt_r <= 8'h00;
         odt_cnt_r <= 8'h00;
         dll_cnt_r <= 8'h00;
      end
      else if (fall)
      begin
         if (pden_ld > pden_cnt_r)
            pden_cnt_r <= pden_ld; // R20
         if (odt_ld > odt_cnt_r)
            odt_cnt_r <= odt_ld; // R16 R17
         if (pd_exit)
            dll_cnt_r <= XPDLL_N; // R18
      end
      else if (rise)
      begin
         if (pden_cnt_r != 8'h00)
            pden_cnt_r <= pden_cnt_r - 8'h01; // R1
         if (odt_cnt_r != 8'h00)
            odt_cnt_r <= odt_cnt_r - 8'h01;
         if (dll_cnt_r != 8'h00)
            dll_cnt_r <= dll_cnt_r - 8'h01;
      end

   // Refresh debt; hot range halves the interval
   assign intv = cfg_r[CFG_HOT] ? {1'b0, refi_r[15:1]} : refi_r; // R15

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         ref_tmr_r <= 16'h0000;
         owed_r <= 4'h0;
      end
      else if (rise)
      begin
         if (ref_tmr_r + 16'h0001 >= intv)
         begin
            ref_tmr_r <= 16'h0000;
            if (owed_r != OWED_MAX)
               owed_r <= owed_r + 4'h1; // R13
         end
         else
            ref_tmr_r <= ref_tmr_r + 16'h0001;
      end
      else if (fall && iss == C_REF && owed_r != 4'h0)
         owed_r <= owed_r - 4'h1;

   // Link outputs straight from registers
   assign link.ck = ck_r;
   assign link.cke = cke_r;
   assign link.odt = odt_r;
   assign link.cmd = cmd_r;
   assign link.addr = addr_r;
endmodule : ddrt_ctrl
`default_nettype wire

// *** rtl/ddrt_pkg.sv ***
// Shared constants and types for the DDR3 command timing link
package ddrt_pkg;
   // System clock and link clock derivation
   localparam int SYS_PS = 5000;
   localparam int CK_HALF = 8;
   localparam int TCK_PS = 2 * CK_HALF * SYS_PS;
   localparam int CW = 8;

   // Whole link edges needed for a time, rounded up
   function automatic int ddrt_ru(input int t_ps, input int tck_ps);
      return (t_ps + tck_ps - 1) / tck_ps;
   endfunction : ddrt_ru

   function automatic int ddrt_max(input int a, input int b);
      return (a > b) ? a : b;
   endfunction : ddrt_max

   // Timing figures in their own units
   localparam int T_XPDLL_NS = 24;
   localparam int XPDLL_MIN_CK = 10;
   localparam int T_WR_MIN_NS = 15;
   localparam logic [CW-1:0] ODT_SHORT_CK = 8'h04;
   localparam logic [CW-1:0] ODT_LONG_CK = 8'h06;
   localparam logic [CW-1:0] REF_PDEN_CK = 8'h01;
   localparam logic [CW-1:0] ACT_PDEN_CK = 8'h01;
   localparam logic [CW-1:0] ZQCS_CK = 8'h40;
   localparam logic [CW-1:0] WR_START_FULL = 8'h04;
   localparam logic [CW-1:0] WR_START_CHOP = 8'h02;
   localparam logic [CW-1:0] ACT_OP_CK = 8'h06;
   localparam logic [CW-1:0] REF_OP_CK = 8'h20;
   localparam logic [3:0] OWED_MAX = 4'h9;

   // Register byte offsets of the controller
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_REFI = 8'h0C;

   // Field positions
   localparam int CMD_ODT = 3;
   localparam int CMD_ADDR = 4;
   localparam int CFG_PD = 0;
   localparam int CFG_HOT = 1;
   localparam int A_WL = 0;
   localparam int A_CHOP = 4;
   localparam int A_WR = 5;
   localparam int A_AP = 10;
   localparam int A_DLLRST = 11;

   // Values after reset
   localparam logic [1:0] CFG_RST = 2'h0;
   localparam logic [15:0] REFI_RST = 16'h0061;
   localparam logic [3:0] WL_RST = 4'h5;
   localparam logic [3:0] WR_RST = 4'h6;

   typedef enum logic [2:0] {C_NOP, C_ACT, C_PRE, C_REF, C_WR, C_RD, C_MRS, C_ZQCS} ddrt_cmd_type;
endpackage : ddrt_pkg

// *** rtl/ddrt_if.sv ***
// Command link between controller and memory
`timescale 1ns/1ps
`default_nettype none
interface ddrt_if;
   logic ck;
   logic cke;
   logic odt;
   logic [2:0] cmd;
   logic [11:0] addr;
   modport ctrl (output ck, output cke, output odt, output cmd, output addr);
   modport mem (input ck, input cke, input odt, input cmd, input addr);
endinterface : ddrt_if
`default_nettype wire

// *** rtl/ddrt_mem.sv ***
// Memory end: command timing behaviour of the device
`timescale 1ns/1ps
`default_nettype none
module ddrt_mem
   import ddrt_pkg::*;
#(
   parameter int TCK_PS_P = TCK_PS
)(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   ddrt_if.mem link,
   output logic o_wr_start,
   output logic o_zq_busy,
   output logic o_low_power,
   output logic o_pd,
   output logic o_timing_err
);
   localparam logic [CW-1:0] XPDLL_N =
      CW'(ddrt_max(XPDLL_MIN_CK, ddrt_ru(T_XPDLL_NS * 1000, TCK_PS_P)));

   logic [2:0] ck_r;
   logic [16:0] bus_m_r;
   logic [16:0] bus_s_r;
   logic rise;
   logic cke;
   logic odt;
   ddrt_cmd_type cmd;
   logic [11:0] addr;
   logic cke_q_r;
   logic odt_q_r;
   logic [3:0] wl_r;
   logic [3:0] wr_r;
   logic chopf_r;
   logic [CW-1:0] wrs_cnt_r;
   logic [CW-1:0] busy_cnt_r;
   logic [CW-1:0] zq_cnt_r;
   logic [CW-1:0] dll_cnt_r;
   logic [CW-1:0] busy_ld;

   // Two stages before use; ck_r[0] feeds only ck_r[1]
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         ck_r <= 3'h0;
         bus_m_r <= 17'h00000;
         bus_s_r <= 17'h00000;
      end
      else if (i_ce)
      begin
         ck_r <= {ck_r[1:0], link.ck};
         bus_m_r <= {link.cke, link.odt, link.cmd, link.addr};
         bus_s_r <= bus_m_r;
      end

   // Edge found on the synchronised clock; every input edge counts
   assign rise = i_ce & ck_r[1] & ~ck_r[2]; // R1
   assign cke = bus_s_r[16];
   assign odt = bus_s_r[15];
   assign cmd = ddrt_cmd_type'(bus_s_r[14:12]);
   assign addr = bus_s_r[11:0];

   // Pending row or refresh work, auto-precharge waits for recovery
   always_comb
   begin
      busy_ld = 8'h00;
      if (cmd == C_ACT || cmd == C_PRE)
         busy_ld = ACT_OP_CK;
      else if (cmd == C_REF)
         busy_ld = REF_OP_CK;
      else if (cmd == C_WR && addr[A_AP])
         busy_ld = CW'(wl_r) + WR_START_FULL + CW'(wr_r); // R3
   end

   // Mode register zero fields and sampled levels
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         wl_r <= WL_RST;
         wr_r <= WR_RST;
         chopf_r <= 1'b0;
         cke_q_r <= 1'b1;
         odt_q_r <= 1'b0;
      end
      else if (rise)
      begin
         cke_q_r <= cke;
         odt_q_r <= odt;
         if (cke && cmd == C_MRS)
         begin
            wl_r <= addr[A_WL +: 4];
            chopf_r <= addr[A_CHOP];
            wr_r <= addr[A_WR +: 4]; // R3
         end
      end

   // Internal write start: four edges after latency, two for fixed chop
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
         wrs_cnt_r <= 8'h00;
      else if (rise)
      begin
         if (cke && cmd == C_WR)
            wrs_cnt_r <= CW'(wl_r) + (chopf_r ? WR_START_CHOP : WR_START_FULL); // R6
         else if (wrs_cnt_r != 8'h00)
            wrs_cnt_r <= wrs_cnt_r - 8'h01;
      end

   // Operation, calibration and DLL relock counters
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         busy_cnt_r <= 8'h00;
         zq_cnt_r <= 8'h00;
         dll_cnt_r <= 8'h00;
      end
      else if (rise)
      begin
         if (cke && busy_ld > busy_cnt_r)
            busy_cnt_r <= busy_ld;
         else if (busy_cnt_r != 8'h00)
            busy_cnt_r <= busy_cnt_r - 8'h01;
         if (cke && cmd == C_ZQCS)
            zq_cnt_r <= ZQCS_CK; // R11
         else if (zq_cnt_r != 8'h00)
            zq_cnt_r <= zq_cnt_r - 8'h01;
         if (cke && !cke_q_r)
            dll_cnt_r <= XPDLL_N - 8'h01; // R4
         else if (dll_cnt_r != 8'h00)
            dll_cnt_r <= dll_cnt_r - 8'h01;
      end

   // Outputs; low current only once row, refresh and auto-precharge work has drained
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
      begin
         o_wr_start <= 1'b0;
         o_zq_busy <= 1'b0;
         o_low_power <= 1'b0;
         o_pd <= 1'b0;
      end
      else if (i_ce)
      begin
         o_wr_start <= rise & (wrs_cnt_r == 8'h01); // R6
         o_zq_busy <= (zq_cnt_r != 8'h00); // R11
         o_pd <= ~cke_q_r;
         o_low_power <= ~cke_q_r & (busy_cnt_r == 8'h00); // R7
      end

   // Read or sync ODT before relock is illegal; sticky until DLL reset
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
         o_timing_err <= 1'b0;
      else if (rise && cke)
      begin
         if ((cmd == C_RD || (odt && !odt_q_r)) && dll_cnt_r != 8'h00)
            o_timing_err <= 1'b1; // R12
         else if (cmd == C_MRS && addr[A_DLLRST])
            o_timing_err <= 1'b0; // R2
      end
endmodule : ddrt_mem
`default_nettype wire

// *** tb/ddrt_assertions.sv ***
// Assertions on the command link between controller and memory
`timescale 1ns/1ps
`default_nettype none
module ddrt_assertions
   import ddrt_pkg::*;
#(
   parameter int CK_HALF_P = CK_HALF
)(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ck,
   input wire logic i_cke,
   input wire logic i_odt,
   input wire logic [2:0] i_cmd,
   input wire logic [11:0] i_addr
);
   localparam int TCKP = 2 * CK_HALF_P * SYS_PS;
   localparam int WRRU = (T_WR_MIN_NS * 1000 + TCKP - 1) / TCKP;
   localparam int XPRU = (T_XPDLL_NS * 1000 + TCKP - 1) / TCKP;
   localparam int XPCK = (XPRU > XPDLL_MIN_CK) ? XPRU : XPDLL_MIN_CK;
   logic ck_q, odt_q, cke_q, chop_r;
   logic [3:0] wl_r, wr_r;
   logic [7:0] hi_cnt, hi_need, wr_cnt, xp_cnt;
   logic ck, cke, odt;
   logic [2:0] cmd;
   logic [11:0] addr;
   // Short names for the watched link
   assign {ck, cke, odt, cmd, addr} = {i_ck, i_cke, i_odt, i_cmd, i_addr};
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // Link state as the memory registers it; cke_q starts high so reset is no exit
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         {ck_q, odt_q, cke_q, chop_r} <= 4'h2;
         {wl_r, wr_r} <= {WL_RST, WR_RST};
         {hi_cnt, hi_need, wr_cnt, xp_cnt} <= 32'h0;
      end
      else
      begin
         ck_q <= ck;
         if (ck && !ck_q)
         begin
            odt_q <= odt;
            cke_q <= cke;
            if (cmd == C_MRS)
               {wr_r, chop_r, wl_r} <= addr[8:0];
            if (odt && (!odt_q || cmd == C_WR))
               hi_cnt <= 8'h01;
            else if (odt && hi_cnt != 8'hFF)
               hi_cnt <= hi_cnt + 8'h01;
            if (odt && (!odt_q || cmd == C_WR))
               hi_need <= (cmd == C_WR && !chop_r && !addr[A_CHOP]) ? ODT_LONG_CK : ODT_SHORT_CK;
            if (cmd == C_WR)
               wr_cnt <= 8'(wl_r) + (chop_r ? WR_START_CHOP : WR_START_FULL)
                  + (addr[A_AP] ? 8'(wr_r) + 8'h01 : 8'(WRRU));
            else if (wr_cnt != 8'h00)
               wr_cnt <= wr_cnt - 8'h01;
            if (cke && !cke_q)
               xp_cnt <= 8'(XPCK);
            else if (xp_cnt != 8'h00)
               xp_cnt <= xp_cnt - 8'h01;
         end
      end
   end
   // A link rise as the memory sees it
   sequence ck_up;
      ck && !ck_q;
   endsequence
   cmd_launch_a: assert property ($changed(cmd) |-> !ck)
      else $error("command moved with link clock high");
   cke_launch_a: assert property ($changed(cke) |-> !ck)
      else $error("clock enable moved with link clock high");
   odt_launch_a: assert property ($changed(odt) |-> !ck)
      else $error("termination moved with link clock high");
   cmd_hold_a: assert property ($changed(cmd) |=> $stable(cmd) [*3])
      else $error("command held too briefly");
   cmd_cke_a: assert property (ck_up ##0 (cmd != C_NOP) |-> cke)
      else $error("command with clock enable low");
   odt_high_a: assert property (ck_up ##0 (!odt && odt_q) |-> hi_cnt >= hi_need)
      else $error("termination dropped early");
   wr_pden_a: assert property (ck_up ##0 (wr_cnt > 8'h01) |-> cke)
      else $error("power-down too soon after write");
   dll_gap_a: assert property (ck_up ##0 (xp_cnt > 8'h01) |-> cmd != C_RD && !(odt && !odt_q))
      else $error("relock gap not kept");
endmodule : ddrt_assertions
`default_nettype wire

// *** tb/ddrt_tb_top.sv ***
// Bench joining controller and memory over the command link
`timescale 1ns/1ps
`default_nettype none
module ddrt_tb_top import ddrt_pkg::*;;
   localparam int HALF = 4;
   logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, er, ck_q;
   logic wr_start, zq_busy, low_power, pd, terr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int n_fail, total_checks, cyc, rises, wr_mark, wr_gap, zq_edges, odt_edges, base, n;
   ddrt_if ddrt_if_i ();
   ddrt_ctrl #(.CK_HALF_P(HALF)) ddrt_ctrl_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .link(ddrt_if_i.ctrl));
   ddrt_mem #(.TCK_PS_P(2 * HALF * SYS_PS)) ddrt_mem_i (.i_clk_sys(clk), .i_rst_n(rst_n),
      .i_ce(ce), .link(ddrt_if_i.mem), .o_wr_start(wr_start), .o_zq_busy(zq_busy),
      .o_low_power(low_power), .o_pd(pd), .o_timing_err(terr));
   ddrt_assertions #(.CK_HALF_P(HALF)) ddrt_assertions_i (.i_clk_sys(clk), .i_rst_n(rst_n),
      .i_ck(ddrt_if_i.ck), .i_cke(ddrt_if_i.cke), .i_odt(ddrt_if_i.odt),
      .i_cmd(ddrt_if_i.cmd), .i_addr(ddrt_if_i.addr));
   // 200 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Link rises counted here, so spans are measured in edges, not time
   always @(posedge clk)
   begin
      ck_q <= ddrt_if_i.ck;
      if (ddrt_if_i.ck && !ck_q)
      begin
         rises <= rises + 1;
         if (ddrt_if_i.cmd == C_WR)
            wr_mark <= rises + 1;
         zq_edges <= zq_edges + int'(zq_busy);
         odt_edges <= odt_edges + int'(ddrt_if_i.odt);
      end
      if (wr_start)
         wr_gap <= rises - wr_mark;
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         n_fail++;
         test_done();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // One APB transfer; answer taken at the edge where pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // Hand over an order and wait until it has left the controller
   task automatic issue(input logic [31:0] w);
      apb(1'b1, REG_CMD, w);
      do
         apb(1'b0, REG_STAT, 32'h0);
      while (rd[0] !== 1'b0);
   endtask : issue
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   initial
   begin
      {rst_n, psel, penable, pwrite} = 4'h0;
      ce = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, REG_STAT, 32'h0);
      check(rd, 32'h0000_3280);
      apb(1'b0, REG_REFI, 32'h0);
      check(rd, 32'h0000_0061);
      apb(1'b0, 8'h10, 32'h0);
      check({rd[30:0], er}, 32'h1);
      apb(1'b1, REG_CFG, 32'h2);
      apb(1'b0, REG_CFG, 32'h0);
      check(rd, 32'h2);
      apb(1'b1, REG_CFG, 32'h0);
      apb(1'b1, REG_REFI, 32'h40);
      // Write start: fixed chop, full burst, then on-the-fly chop
      for (int i = 0; i < 3; i++)
      begin
         issue({16'h0, 3'h0, 4'h5, i == 0, 4'h6, 1'b0, C_MRS});
         apb(1'b0, REG_STAT, 32'h0);
         check(32'(rd[15:7]), 32'({i == 0, 8'h56}));
         issue({16'h0, 7'h0, i == 2, 4'h0, 1'b0, C_WR});
         while (wr_start !== 1'b1)
            @(posedge clk);
         @(posedge clk);
         check(32'(wr_gap), (i == 0) ? 32'h8 : 32'hA);
      end
      // Termination spans, plain and with a full-length write
      base = odt_edges;
      issue(32'h8);
      issue(32'h0);
      check(32'(odt_edges - base), 32'h4);
      base = odt_edges;
      issue(32'hC);
      issue(32'h0);
      check(32'(odt_edges - base), 32'h6);
      // Power-down behind a row activation; held order; exit keeps relock gap
      issue(32'h1);
      apb(1'b1, REG_CFG, 32'h1);
      while (pd !== 1'b1)
         @(posedge clk);
      check(32'(low_power), 32'h0);
      while (low_power !== 1'b1)
         @(posedge clk);
      apb(1'b0, REG_STAT, 32'h0);
      check(32'(rd[1]), 32'h1);
      apb(1'b1, REG_CMD, 32'h5);
      apb(1'b1, REG_CMD, 32'h5);
      check(32'(er), 32'h1);
      apb(1'b1, REG_CFG, 32'h0);
      do
         apb(1'b0, REG_STAT, 32'h0);
      while (rd[0] !== 1'b0);
      // Memory sees the read a link edge plus sync latency after it leaves
      repeat (4 * HALF) @(posedge clk);
      check(32'(terr), 32'h0);
      // Power-down in the hot range left by force once refreshes are owed
      apb(1'b1, REG_CFG, 32'h3);
      while (pd !== 1'b1)
         @(posedge clk);
      n = 0;
      while (pd === 1'b1)
      begin
         n++;
         @(posedge clk);
      end
      check(32'(n <= 9 * 32 * 2 * HALF + 64), 32'h1);
      apb(1'b1, REG_CFG, 32'h0);
      // Short calibration length
      base = zq_edges;
      issue(32'h7);
      while (zq_busy !== 1'b1)
         @(posedge clk);
      while (zq_busy === 1'b1)
         @(posedge clk);
      repeat (2) @(posedge clk);
      check(32'(zq_edges - base), 32'h40);
      check(32'(terr), 32'h0);
      // System clock enable ce low must hold the link clock still
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      base = int'(ddrt_if_i.ck);
      repeat (20) @(posedge clk);
      check(32'(ddrt_if_i.ck), 32'(base));
      ce <= 1'b1;
      test_done();
   end
endmodule : ddrt_tb_top
`default_nettype wire
